/* File: verification/frame_host_model.sv */
// host capture model: measures rows and pixels of every frame
// assumes frame and line valid are registered on pixClk
`timescale 1ns/100ps

module frame_host_model (
	input  wire logic        pixClk,
	input  wire logic        reset,
	input  wire logic        frameValidOut,
	input  wire logic        lineValidOut,
	input  wire logic [15:0] rowAddrOut,
	input  wire logic [15:0] rowPairOut,
	output int               frameCount,
	output int               lineCount,
	output int               lineWidth,
	output logic [15:0]      firstRow,
	output logic [15:0]      pairOff,
	output int               blankLen
);
	int   pixRun;
	int   fvRun;
	logic fvLast;
	logic lvLast;

	// ------------------------------------------------------------
	// capture
	// ------------------------------------------------------------
	always @(posedge pixClk)
	begin
		fvLast <= frameValidOut;
		lvLast <= lineValidOut;
		if (reset)
		begin
			frameCount <= 0;
			lineCount <= 0;
			pixRun <= 0;
			fvRun <= 0;
		end
		else
		begin
			if (frameValidOut && !fvLast)
				lineCount <= 0;
			if (lineValidOut && !lvLast)
			begin
				lineCount <= (frameValidOut && !fvLast) ? 1 : lineCount + 1;
				if (!fvLast || (frameValidOut && !fvLast) || lineCount == 0)
				begin
					firstRow <= rowAddrOut;
					pairOff <= rowPairOut - rowAddrOut;
				end
			end
			pixRun <= lineValidOut ? pixRun + 1 : 0;
			fvRun <= frameValidOut ? 0 : fvRun + 1;
			// gap before each frame, bubble included
			if (frameValidOut && !fvLast)
				blankLen <= fvRun;
			if (!lineValidOut && lvLast)
				lineWidth <= pixRun;
			// count every fall of frame valid, an abort still ends one
			if (!frameValidOut && fvLast)
				frameCount <= frameCount + 1;
		end
	end
endmodule

/* File: verification/frame_readout_timing_control_tb_top.sv */
// self-checking bench of the frame readout timing controller
// assumes the host capture model; 20 ns system, 12 ns pixel clock
`timescale 1ns/100ps

module frame_readout_timing_control_tb_top;
	logic                     clk_sys = 0;
	logic                     pixClk = 0;
	logic                     reset = 1;
	logic                     wrValid = 0;
	frame_timing_pkg::field_t wrField = frame_timing_pkg::F_FIRST_ROW;
	logic [15:0]              wrData = 16'h0000;
	logic                     triggerPin = 0;
	logic                     frameValidOut;
	logic                     lineValidOut;
	logic [15:0]              rowAddrOut;
	logic [15:0]              rowPairOut;
	logic                     allRowsResetOut;
	logic [39:0]              exposureDurOut;
	logic                     reinitPendingOut;
	int                       frameCount;
	int                       lineCount;
	int                       lineWidth;
	logic [15:0]              firstRow;
	logic [15:0]              pairOff;
	int                       blankLen;
	int                       b0;
	int                       tr;
	int                       av;
	int                       sw;
	int                       bad_count = 0;
	int                       check_count = 0;
	int                       n;
	logic [31:0]              rnd = 32'h3335_55da;

	always #10 clk_sys = ~clk_sys;
	always #6 pixClk = ~pixClk;

	frame_readout_timing_control #(.ALLRESET_LEN(16)) i_dut (
		.clk_sys(clk_sys), .reset(reset), .pixClk(pixClk),
		.wrValid(wrValid), .wrField(wrField), .wrData(wrData),
		.triggerPin(triggerPin), .frameValidOut(frameValidOut),
		.lineValidOut(lineValidOut), .rowAddrOut(rowAddrOut),
		.rowPairOut(rowPairOut), .shutterRowOut(),
		.shutterValidOut(), .allRowsResetOut(allRowsResetOut),
		.exposureDurOut(exposureDurOut),
		.reinitPendingOut(reinitPendingOut));

	frame_host_model i_host (
		.pixClk(pixClk), .reset(reset), .frameValidOut(frameValidOut),
		.lineValidOut(lineValidOut), .rowAddrOut(rowAddrOut),
		.rowPairOut(rowPairOut), .frameCount(frameCount),
		.lineCount(lineCount), .lineWidth(lineWidth),
		.firstRow(firstRow), .pairOff(pairOff), .blankLen(blankLen));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input frame_timing_pkg::field_t f,
		input logic [15:0] d);
		@(negedge clk_sys);
		wrValid = 1'b1;
		wrField = f;
		wrData = d;
		@(negedge clk_sys);
		wrValid = 1'b0;
	endtask

	task automatic waitFv();
		int k;
		for (k = 0; k < 50000 && frameValidOut !== 1'b0; k++)
			@(negedge clk_sys);
		for (k = 0; k < 50000 && frameValidOut !== 1'b1; k++)
			@(negedge clk_sys);
		chk(40'(frameValidOut), 40'h1);
	endtask

	task automatic frames(input int cnt);
		int k;
		int target;
		target = frameCount + cnt;
		for (k = 0; k < 30000 && frameCount < target; k++)
			@(negedge clk_sys);
		chk(40'(frameCount >= target), 40'h1);
	endtask

	function automatic int durOf(input int r);
		int ceil;
		int ovh;
		if (r < 1)
			r = 1;
		ceil = r < 3 ? 1232 : 1504;
		ovh = 208 * (av + 1) + 98 + (tr + 1 < ceil ? tr + 1 : ceil) - 94;
		// row period is 64 pixels plus a 4 pixel gap here
		return (r * 68 > 2 * ovh) ? r * 68 - 2 * ovh : 0;
	endfunction

	task automatic expoCase();
		rnd = xs(rnd);
		sw = 32 * rnd[0] + rnd[5:1];
		tr = rnd[16:6];
		av = rnd[18:17];
		waitFv();
		wr(frame_timing_pkg::F_EXP_HIGH, 16'(rnd[0]));
		wr(frame_timing_pkg::F_EXP_LOW, 16'(rnd[5:1]));
		wr(frame_timing_pkg::F_TRIM, 16'(tr));
		wr(frame_timing_pkg::F_VAVG, 16'(av));
		frames(4);
		chk(exposureDurOut, 40'(durOf(sw)));
		chk(40'(pairOff), 40'(av != 0 ? 2 : 0));
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		#1_500_000;
		bad_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		stop_test();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(negedge clk_sys);
		reset = 0;
		for (n = 0; n < 500 && allRowsResetOut !== 1'b1; n++)
			@(negedge clk_sys);
		chk(40'(allRowsResetOut), 40'h1);
		frames(2);
		chk(40'(lineCount), 40'h8);
		chk(40'(lineWidth), 40'h10);
		chk(40'(firstRow), 40'h0);
		b0 = blankLen;
		$display("test default frame done");
		waitFv();
		wr(frame_timing_pkg::F_VFLIP, 16'h0001);
		wr(frame_timing_pkg::F_VAVG, 16'h0001);
		frames(2);
		chk(40'(firstRow), 40'h7);
		chk(40'(pairOff), 40'h2);
		chk(40'(blankLen > b0 + 75 && blankLen < b0 + 85), 40'h1);
		waitFv();
		wr(frame_timing_pkg::F_VFLIP, 16'h0000);
		wr(frame_timing_pkg::F_WIDTH, 16'h003f);
		wr(frame_timing_pkg::F_VSUB, 16'h0001);
		frames(2);
		chk(40'(lineCount), 40'h4);
		chk(40'(lineWidth), 40'h40);
		chk(40'(firstRow), 40'h0);
		waitFv();
		wr(frame_timing_pkg::F_VSUB, 16'h0000);
		$display("test geometry done");
		repeat (3) expoCase();
		$display("test exposure done");
		tr = 0;
		av = 0;
		waitFv();
		wr(frame_timing_pkg::F_TRIM, 16'h0000);
		wr(frame_timing_pkg::F_VAVG, 16'h0000);
		wr(frame_timing_pkg::F_HOLD_BRIGHT, 16'h0001);
		wr(frame_timing_pkg::F_EXP_HIGH, 16'h0001);
		wr(frame_timing_pkg::F_EXP_LOW, 16'h001f);
		frames(4);
		chk(exposureDurOut, 40'(durOf(sw)));
		wr(frame_timing_pkg::F_HOLD_BRIGHT, 16'h0000);
		frames(4);
		chk(exposureDurOut, 40'(durOf(63)));
		$display("test brightness hold done");
		waitFv();
		wr(frame_timing_pkg::F_HOLD_REFRAME, 16'h0001);
		wr(frame_timing_pkg::F_REINIT, 16'h0001);
		repeat (3) @(negedge clk_sys);
		chk(40'(reinitPendingOut), 40'h1);
		repeat (400) @(negedge clk_sys);
		n = frameCount;
		repeat (2000) @(negedge clk_sys);
		chk(40'(frameCount), 40'(n));
		wr(frame_timing_pkg::F_HOLD_REFRAME, 16'h0000);
		wr(frame_timing_pkg::F_REINIT, 16'h0001);
		frames(2);
		chk(40'(lineCount), 40'h8);
		chk(40'(reinitPendingOut), 40'h0);
		$display("test restart done");
		waitFv();
		wr(frame_timing_pkg::F_MODE, 16'h0003);
		frames(1);
		wr(frame_timing_pkg::F_HEIGHT, 16'h0003);
		n = frameCount;
		// wait beyond the full reset period
		repeat (200) @(negedge clk_sys);
		chk(40'(frameCount), 40'(n));
		triggerPin = 1'b1;
		frames(1);
		triggerPin = 1'b0;
		chk(40'(allRowsResetOut), 40'h1);
		chk(40'(lineCount), 40'h4);
		$display("test triggered capture done");
		stop_test();
	end
endmodule

/* File: verilog/frame_readout_timing_control.sv */
// frame readout timing: row order, write timing against frames,
// restart/pause, rolling and simultaneous-reset shutter sequencing.
// assumes a config writer on clk_sys and a free-running pixel clock.
`timescale 1ns/100ps

module frame_readout_timing_control #(
	parameter int ALLRESET_LEN = frame_timing_pkg::ALLRESET_CYCLES
) (
	input  wire logic                     clk_sys,
	input  wire logic                     reset,
	input  wire logic                     pixClk,
	input  wire logic                     wrValid,
	input  wire frame_timing_pkg::field_t wrField,
	input  wire logic [15:0]              wrData,
	input  wire logic                     triggerPin,
	output logic                          frameValidOut,
	output logic                          lineValidOut,
	output logic [15:0]                   rowAddrOut,
	output logic [15:0]                   rowPairOut,
	output logic [15:0]                   shutterRowOut,
	output logic                          shutterValidOut,
	output logic                          allRowsResetOut,
	output logic [39:0]                   exposureDurOut,
	output logic                          reinitPendingOut
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [21:0] rowCountOf(frame_timing_pkg::expo_t e);
		logic [21:0] s;
		s = {1'b0, e.high, 5'h00} + {6'h00, e.low};
		rowCountOf = (s == 22'h00_0000) ? 22'h00_0001 : s;
	endfunction

	function automatic logic [16:0] widthEffOf(frame_timing_pkg::geom_t g);
		widthEffOf = ({1'b0, g.widthM1} + 17'h0_0001) >> g.hSub;
	endfunction

	function automatic logic [16:0] gapOf(frame_timing_pkg::geom_t g);
		gapOf = (g.lineGap == 16'h0000) ? 17'h0_0001 : {1'b0, g.lineGap};
	endfunction

	function automatic logic [17:0] rowPeriodOf(frame_timing_pkg::geom_t g);
		rowPeriodOf = {1'b0, widthEffOf(g)} + {1'b0, gapOf(g)};
	endfunction

	// ----------------------------------------------------------------
	// clk_sys side: staged configuration
	// ----------------------------------------------------------------
	frame_timing_pkg::geom_t geomStg_ff;
	frame_timing_pkg::expo_t expoStg_ff;
	frame_timing_pkg::expo_t expoHeld_ff;
	frame_timing_pkg::expo_t expoPipe_ff;
	frame_timing_pkg::mode_t modeStg_ff;
	frame_timing_pkg::xfer_t xfer_ff;
	logic holdBright_ff;
	logic holdReframe_ff;
	logic bubble_ff;
	logic ersEntry_ff;
	logic restartPend_ff;
	logic restartTgl_ff;
	logic xferTgl_ff;
	logic reqS1_ff;
	logic reqS2_ff;
	logic reqS3_ff;
	logic reqTgl_ff;
	logic captureEv;
	logic bubbleWrite;
	logic reinitWrite;

	assign captureEv   = reqS2_ff ^ reqS3_ff;
	assign reinitWrite = wrValid && wrField == frame_timing_pkg::F_REINIT
		&& wrData[0];
	always_comb
	begin
		unique case (wrField)
			frame_timing_pkg::F_FIRST_ROW, frame_timing_pkg::F_HEIGHT,
			frame_timing_pkg::F_WIDTH, frame_timing_pkg::F_LINE_GAP,
			frame_timing_pkg::F_FRAME_GAP, frame_timing_pkg::F_TRIM,
			frame_timing_pkg::F_VFLIP, frame_timing_pkg::F_VAVG,
			frame_timing_pkg::F_VSUB, frame_timing_pkg::F_HSUB:
				bubbleWrite = wrValid && !modeStg_ff.triggered;
			default:
				bubbleWrite = 1'b0;
		endcase
	end

	// geometry staged; reaches the link only at a frame boundary
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			geomStg_ff <= frame_timing_pkg::GEOM_RST;
		else if (wrValid)
		begin
			unique case (wrField)
				frame_timing_pkg::F_FIRST_ROW: geomStg_ff.firstRow <= wrData;
				frame_timing_pkg::F_HEIGHT:    geomStg_ff.heightM1 <= wrData;
				frame_timing_pkg::F_WIDTH:     geomStg_ff.widthM1  <= wrData;
				frame_timing_pkg::F_LINE_GAP:  geomStg_ff.lineGap  <= wrData;
				frame_timing_pkg::F_FRAME_GAP: geomStg_ff.frameGap <= wrData;
				frame_timing_pkg::F_TRIM:      geomStg_ff.trim     <= wrData;
				frame_timing_pkg::F_VFLIP:     geomStg_ff.vFlip <= wrData[0];
				frame_timing_pkg::F_VAVG:      geomStg_ff.vAvg <= wrData[1:0];
				frame_timing_pkg::F_VSUB:      geomStg_ff.vSub <= wrData[1:0];
				frame_timing_pkg::F_HSUB:      geomStg_ff.hSub <= wrData[1:0];
				default: ;
			endcase
		end
	end

	// held copy always tracks writes; live copy only when not held
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			expoStg_ff  <= frame_timing_pkg::EXPO_RST;
			expoHeld_ff <= frame_timing_pkg::EXPO_RST;
		end
		else if (wrValid && wrField == frame_timing_pkg::F_EXP_LOW)
		begin
			expoHeld_ff.low <= wrData;
			if (!holdBright_ff)
				expoStg_ff.low <= wrData;
		end
		else if (wrValid && wrField == frame_timing_pkg::F_EXP_HIGH)
		begin
			expoHeld_ff.high <= wrData;
			if (!holdBright_ff)
				expoStg_ff.high <= wrData;
		end
		else if (wrValid && wrField == frame_timing_pkg::F_HOLD_BRIGHT
			&& !wrData[0] && holdBright_ff)
			expoStg_ff <= expoHeld_ff;
	end

	// hold bits act as soon as written; mode is staged until the next capture
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			holdBright_ff  <= 1'b0;
			holdReframe_ff <= 1'b0;
			modeStg_ff     <= frame_timing_pkg::MODE_RST;
		end
		else if (wrValid)
		begin
			if (wrField == frame_timing_pkg::F_HOLD_BRIGHT)
				holdBright_ff <= wrData[0];
			if (wrField == frame_timing_pkg::F_HOLD_REFRAME)
				holdReframe_ff <= wrData[0];
			if (wrField == frame_timing_pkg::F_MODE)
				modeStg_ff <= '{wrData[1], wrData[0]};
		end
	end

	// a listed write outside triggered mode marks a bubble; set wins over capture clear
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			bubble_ff <= 1'b0;
		else if (bubbleWrite)
			bubble_ff <= 1'b1;
		else if (captureEv)
			bubble_ff <= 1'b0;
	end

	// every write selecting rolling mode asks for the reset sweep
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			ersEntry_ff <= 1'b0;
		else if (wrValid && wrField == frame_timing_pkg::F_MODE && !wrData[1])
			ersEntry_ff <= 1'b1;
		else if (captureEv)
			ersEntry_ff <= 1'b0;
	end

	// reinit stays pending while paused; cleared once released
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			restartPend_ff <= 1'b0;
			restartTgl_ff  <= 1'b0;
		end
		else if (reinitWrite)
		begin
			restartPend_ff <= 1'b1;
			if (!restartPend_ff)
				restartTgl_ff <= ~restartTgl_ff;
		end
		else if (captureEv && !holdReframe_ff)
			restartPend_ff <= 1'b0;
	end

	// exposure passes a one-frame pipe, so it lands two frames on
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			reqS1_ff    <= 1'b0;
			reqS2_ff    <= 1'b0;
			reqS3_ff    <= 1'b0;
			xferTgl_ff  <= 1'b0;
			expoPipe_ff <= frame_timing_pkg::EXPO_RST;
			xfer_ff     <= '{frame_timing_pkg::GEOM_RST,
				frame_timing_pkg::EXPO_RST, frame_timing_pkg::MODE_RST,
				1'b0, 1'b0, 1'b1};
		end
		else
		begin
			reqS1_ff <= reqTgl_ff;
			reqS2_ff <= reqS1_ff;
			reqS3_ff <= reqS2_ff;
			if (captureEv)
			begin
				expoPipe_ff  <= expoStg_ff;
				xfer_ff.geom <= geomStg_ff;
				xfer_ff.mode <= modeStg_ff;
				// restart skips the pipe: exposure applies at once
				xfer_ff.expo <= restartPend_ff ? expoStg_ff : expoPipe_ff;
				xfer_ff.bubble   <= bubble_ff;
				xfer_ff.restart  <= restartPend_ff;
				xfer_ff.ersEntry <= ersEntry_ff;
				xferTgl_ff <= ~xferTgl_ff;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			reinitPendingOut <= 1'b0;
		else
			reinitPendingOut <= restartPend_ff;
	end

	// ----------------------------------------------------------------
	// pixel clock side
	// ----------------------------------------------------------------
	frame_timing_pkg::pix_state_t state_ff;
	frame_timing_pkg::xfer_t      act_ff;
	logic        rstS1_ff;
	logic        rstPix;
	logic        ackS1_ff, ackS2_ff, ackS3_ff;
	logic        reS1_ff, reS2_ff, reS3_ff;
	logic        hrS1_ff, hrS2_ff;
	logic        trS1_ff, trS2_ff;
	logic        abort_ff;
	logic        pause_ff;
	logic [39:0] cnt_ff;
	logic [15:0] rowCnt_ff;
	logic [39:0] target;
	logic        cntDone;
	logic        ackEv;
	logic        restartEv;
	logic [15:0] rowsEff;
	logic [15:0] rowStep;
	logic [15:0] rowAddr;
	logic [15:0] shutIdx;
	logic [21:0] rowCount;
	logic [11:0] trimEff;
	logic [11:0] trimCeil;
	logic [12:0] overhead;
	logic [39:0] rowsTime;
	logic [39:0] expDur;

	assign ackEv     = ackS2_ff ^ ackS3_ff;
	assign restartEv = reS2_ff ^ reS3_ff;

	always_ff @(posedge pixClk)
	begin
		rstS1_ff <= reset;
		rstPix   <= rstS1_ff;
		ackS1_ff <= xferTgl_ff;
		ackS2_ff <= ackS1_ff;
		ackS3_ff <= ackS2_ff;
		reS1_ff  <= restartTgl_ff;
		reS2_ff  <= reS1_ff;
		reS3_ff  <= reS2_ff;
		hrS1_ff  <= holdReframe_ff;
		hrS2_ff  <= hrS1_ff;
		trS1_ff  <= triggerPin;
		trS2_ff  <= trS1_ff;
	end

	// bubble and gaps timed with the settings now in force
	assign rowCount = rowCountOf(act_ff.expo);
	assign rowsTime = 40'(rowCount) * 40'(rowPeriodOf(act_ff.geom));
	assign rowsEff  = 16'(({1'b0, act_ff.geom.heightM1} + 17'h0_0001)
		>> act_ff.geom.vSub);
	always_comb
	begin
		unique case (state_ff)
			frame_timing_pkg::S_ALLRESET: target = 40'(ALLRESET_LEN);
			frame_timing_pkg::S_BUBBLE:   target = rowsTime;
			frame_timing_pkg::S_ROWS:     target = 40'(widthEffOf(act_ff.geom));
			frame_timing_pkg::S_GAP:      target = 40'(gapOf(act_ff.geom));
			frame_timing_pkg::S_ABORT:
				target = 40'(rowPeriodOf(act_ff.geom));
			frame_timing_pkg::S_VBLANK:
				target = 40'(rowPeriodOf(act_ff.geom)) *
					(40'(act_ff.geom.frameGap) + 40'h00_0000_0001);
			default: target = 40'h00_0000_0001;
		endcase
		cntDone = cnt_ff >= target - 40'h00_0000_0001;
	end

	always_ff @(posedge pixClk)
	begin
		if (rstPix)
			abort_ff <= 1'b0;
		else if (restartEv)
			abort_ff <= 1'b1;
		else if (state_ff == frame_timing_pkg::S_ABORT)
			abort_ff <= 1'b0;
	end

	// pause after a restart while hold-after-reframe is set
	always_ff @(posedge pixClk)
	begin
		if (rstPix)
			pause_ff <= 1'b0;
		else if (state_ff == frame_timing_pkg::S_ABORT && cntDone)
			pause_ff <= hrS2_ff;
		else if (!hrS2_ff)
			pause_ff <= 1'b0;
	end

	always_ff @(posedge pixClk)
	begin
		if (rstPix)
		begin
			state_ff  <= frame_timing_pkg::S_ALLRESET;
			cnt_ff    <= 40'h00_0000_0000;
			rowCnt_ff <= 16'h0000;
			reqTgl_ff <= 1'b0;
			act_ff    <= '{frame_timing_pkg::GEOM_RST,
				frame_timing_pkg::EXPO_RST, frame_timing_pkg::MODE_RST,
				1'b0, 1'b0, 1'b0};
		end
		else
		begin
			cnt_ff <= cnt_ff + 40'h00_0000_0001;
			unique case (state_ff)
				frame_timing_pkg::S_ALLRESET:
					if (cntDone)
						state_ff <= frame_timing_pkg::S_WAIT;
				// gap writes are captured on leaving wait; in triggered mode only once the trigger is seen
				frame_timing_pkg::S_WAIT:
					if (abort_ff)
						state_ff <= frame_timing_pkg::S_ABORT;
					else if (!pause_ff && (!act_ff.mode.triggered || trS2_ff))
					begin
						state_ff  <= frame_timing_pkg::S_SYNC;
						reqTgl_ff <= ~reqTgl_ff;
					end
				frame_timing_pkg::S_SYNC:
					if (ackEv)
					begin
						act_ff    <= xfer_ff;
						rowCnt_ff <= 16'h0000;
						// rolling entry sweeps all rows before readout
						// so does the first frame in simultaneous mode
						if ((xfer_ff.ersEntry && !xfer_ff.mode.simReset)
							|| (xfer_ff.mode.simReset && !act_ff.mode.simReset))
							state_ff <= frame_timing_pkg::S_ALLRESET;
						else if (xfer_ff.bubble)
							state_ff <= frame_timing_pkg::S_BUBBLE;
						else
							state_ff <= frame_timing_pkg::S_ROWS;
					end
				frame_timing_pkg::S_BUBBLE:
					if (abort_ff)
						state_ff <= frame_timing_pkg::S_ABORT;
					else if (cntDone)
						state_ff <= frame_timing_pkg::S_ROWS;
				frame_timing_pkg::S_ROWS:
					if (cntDone)
						state_ff <= frame_timing_pkg::S_GAP;
				// current row ends, then one further row, then restart
				frame_timing_pkg::S_GAP:
					if (cntDone)
					begin
						rowCnt_ff <= rowCnt_ff + 16'h0001;
						if (abort_ff)
							state_ff <= frame_timing_pkg::S_ABORT;
						// simultaneous mode sweeps right after the frame
						else if (rowCnt_ff + 16'h0001 >= rowsEff)
							state_ff <= act_ff.mode.simReset ?
								frame_timing_pkg::S_ALLRESET :
								frame_timing_pkg::S_VBLANK;
						else
							state_ff <= frame_timing_pkg::S_ROWS;
					end
				frame_timing_pkg::S_ABORT:
					if (cntDone)
						state_ff <= frame_timing_pkg::S_WAIT;
				frame_timing_pkg::S_VBLANK:
					if (abort_ff)
						state_ff <= frame_timing_pkg::S_ABORT;
					else if (cntDone)
						state_ff <= frame_timing_pkg::S_WAIT;
			endcase
			if (state_ff == frame_timing_pkg::S_SYNC || cntDone)
				cnt_ff <= 40'h00_0000_0000;
		end
	end

	// flipped readout descends from the window end
	// only active rows are addressed, dark rows never reorder
	assign rowStep = 16'(rowCnt_ff << act_ff.geom.vSub);
	assign rowAddr = act_ff.geom.vFlip ?
		act_ff.geom.firstRow + act_ff.geom.heightM1 - rowStep :
		act_ff.geom.firstRow + rowStep;
	// release pass runs the exposure row count ahead of readout
	assign shutIdx = rowCnt_ff + 16'(rowCount);

	// overhead built from averaging, offsets and trim
	// trim ceiling picked by exposure row count
	assign trimCeil = (rowCount < frame_timing_pkg::CEIL_ROW_LIMIT) ?
		frame_timing_pkg::CEIL_SHORT : frame_timing_pkg::CEIL_LONG;
	assign trimEff  = (act_ff.geom.trim + 16'h0001 < 16'(trimCeil)) ?
		12'(act_ff.geom.trim + 16'h0001) : trimCeil;
	assign overhead = 13'(frame_timing_pkg::OVH_PER_AVG *
		(12'(act_ff.geom.vAvg) + 12'h001)) + 13'(frame_timing_pkg::OVH_ADD)
		+ 13'(trimEff) - 13'(frame_timing_pkg::OVH_SUB);
	assign expDur = (rowsTime > 40'({overhead, 1'b0})) ?
		rowsTime - 40'({overhead, 1'b0}) : 40'h00_0000_0000;

	// row-major: line valid per row, frame valid across rows
	always_ff @(posedge pixClk)
	begin
		if (rstPix)
		begin
			frameValidOut   <= 1'b0;
			lineValidOut    <= 1'b0;
			rowAddrOut      <= 16'h0000;
			rowPairOut      <= 16'h0000;
			shutterRowOut   <= 16'h0000;
			shutterValidOut <= 1'b0;
			allRowsResetOut <= 1'b0;
			exposureDurOut  <= 40'h00_0000_0000;
		end
		else
		begin
			frameValidOut <= state_ff == frame_timing_pkg::S_ROWS
				|| state_ff == frame_timing_pkg::S_GAP;
			lineValidOut  <= state_ff == frame_timing_pkg::S_ROWS;
			rowAddrOut    <= rowAddr;
			// averaging partner is the same colour, higher index
			rowPairOut    <= (act_ff.geom.vAvg != 2'h0) ?
				rowAddr + 16'h0002 : rowAddr;
			shutterRowOut <= shutIdx;
			shutterValidOut <= !act_ff.mode.simReset && shutIdx < rowsEff
				&& state_ff == frame_timing_pkg::S_ROWS;
			allRowsResetOut <= state_ff == frame_timing_pkg::S_ALLRESET;
			exposureDurOut  <= expDur;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence frameEnd;
		$fell(frameValidOut) && act_ff.mode.simReset && !abort_ff;
	endsequence

	a_bubble_mark: assert property (@(posedge clk_sys) disable iff (reset)
		bubbleWrite |=> bubble_ff)
		else $error("bubble flag not set by listed write");
	a_lv_in_fv: assert property (@(posedge pixClk) disable iff (rstPix)
		lineValidOut |-> frameValidOut)
		else $error("line valid outside frame valid");
	a_flip_descend: assert property (@(posedge pixClk) disable iff (rstPix)
		act_ff.geom.vFlip && $changed(rowCnt_ff) && rowCnt_ff != 16'h0000
		&& rowCnt_ff < rowsEff |=> rowAddrOut < $past(rowAddrOut))
		else $error("flipped rows not descending");
	a_pair_higher: assert property (@(posedge pixClk) disable iff (rstPix)
		act_ff.geom.vAvg != 2'h0 && $stable(act_ff)
		|=> rowPairOut == rowAddrOut + 16'h0002)
		else $error("averaging pair not at higher row");
	a_allreset_hold: assert property (@(posedge pixClk) disable iff (rstPix)
		$rose(allRowsResetOut) |-> allRowsResetOut [*8])
		else $error("all-row reset cut short");
	a_grr_reset: assert property (@(posedge pixClk) disable iff (rstPix)
		frameEnd |-> ##[0:2] allRowsResetOut)
		else $error("no all-row reset after frame");
	a_trim_ceil: assert property (@(posedge pixClk) disable iff (rstPix)
		trimEff <= ((rowCount < 22'h00_0003) ? 12'h4d0 : 12'h5e0))
		else $error("trim exceeds ceiling");
	a_pause_quiet: assert property (@(posedge pixClk) disable iff (rstPix)
		pause_ff && state_ff == frame_timing_pkg::S_WAIT |=> ##1 !frameValidOut)
		else $error("frame started while paused");

endmodule

/* File: verilog/frame_timing_pkg.sv */
// shared types and constants of the frame readout timing controller
// assumes a host-side writer on clk_sys and a pixel-rate link clock

package frame_timing_pkg;

	// ----------------------------------------------------------------
	// configuration fields addressed by the write port
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		F_FIRST_ROW, F_HEIGHT, F_WIDTH, F_LINE_GAP, F_FRAME_GAP, F_TRIM,
		F_VFLIP, F_VAVG, F_VSUB, F_HSUB, F_EXP_LOW, F_EXP_HIGH,
		F_HOLD_BRIGHT, F_HOLD_REFRAME, F_REINIT, F_MODE
	} field_t;

	typedef struct packed {
		logic [15:0] firstRow;
		logic [15:0] heightM1;
		logic [15:0] widthM1;
		logic [15:0] lineGap;
		logic [15:0] frameGap;
		logic [15:0] trim;
		logic        vFlip;
		logic [1:0]  vAvg;
		logic [1:0]  vSub;
		logic [1:0]  hSub;
	} geom_t;

	typedef struct packed {
		logic [15:0] low;
		logic [15:0] high;
	} expo_t;

	// mode bit0: triggered capture, bit1: simultaneous reset exposure
	typedef struct packed {
		logic simReset;
		logic triggered;
	} mode_t;

	typedef struct packed {
		geom_t geom;
		expo_t expo;
		mode_t mode;
		logic  bubble;
		logic  restart;
		logic  ersEntry;
	} xfer_t;

	typedef enum logic [2:0] {
		S_ALLRESET, S_WAIT, S_SYNC, S_BUBBLE, S_ROWS, S_GAP, S_ABORT,
		S_VBLANK
	} pix_state_t;

	// ----------------------------------------------------------------
	// reset values and arithmetic constants
	// ----------------------------------------------------------------
	localparam geom_t GEOM_RST = '{16'h0000, 16'h0007, 16'h000f,
		16'h0004, 16'h0002, 16'h0000, 1'b0, 2'h0, 2'h0, 2'h0};
	localparam expo_t EXPO_RST = '{16'h0004, 16'h0000};
	localparam mode_t MODE_RST = '{1'b0, 1'b0};
	localparam logic [4:0]  EXP_HIGH_SHIFT = 5'h05;
	localparam logic [11:0] OVH_PER_AVG    = 12'h0d0;
	localparam logic [11:0] OVH_ADD        = 12'h062;
	localparam logic [11:0] OVH_SUB        = 12'h05e;
	localparam logic [11:0] CEIL_SHORT     = 12'h4d0;
	localparam logic [11:0] CEIL_LONG      = 12'h5e0;
	localparam logic [21:0] CEIL_ROW_LIMIT = 22'h00_0003;
	localparam int ALLRESET_ROWS     = 16;
	localparam int ALLRESET_ACLK_ROW = 2004;
	localparam int PIX_PER_ACLK      = 2;
	localparam int ALLRESET_CYCLES   =
		ALLRESET_ROWS * ALLRESET_ACLK_ROW * PIX_PER_ACLK;

endpackage
